// ---- rtl/fmc_pkg.sv ----
package fmc_pkg;
    // register offsets
    localparam logic [7:0] ADDR_FRAMER_MODE_ONE = 8'h1D;
    localparam logic [7:0] ADDR_FREEZE          = 8'h40;
    localparam logic [7:0] ADDR_LINE_CTRL       = 8'h41;
    localparam logic [7:0] ADDR_FEC_LO          = 8'h42;
    localparam logic [7:0] ADDR_FEC_HI          = 8'h43;
    localparam logic [7:0] ADDR_CEC_LO          = 8'h44;
    localparam logic [7:0] ADDR_CEC_HI          = 8'h45;
    localparam logic [7:0] ADDR_CVC_LO          = 8'h46;
    localparam logic [7:0] ADDR_CVC_HI          = 8'h47;
    localparam logic [7:0] ADDR_EBC_LO          = 8'h48;
    localparam logic [7:0] ADDR_EBC_HI          = 8'h49;
    // framer mode one field positions
    localparam int BIT_CHAN_MAP   = 7;
    localparam int BIT_LINK_INS   = 6;
    localparam int BIT_PCM_STD    = 5;
    localparam int BIT_CRC6_EN    = 4;
    localparam int BIT_ECM        = 3;
    localparam int BIT_RATE_LO    = 2;
    localparam int BIT_SEND_AIS   = 0;
    // line control register fields
    localparam int BIT_RATE_HI    = 0;
    localparam int BIT_RATE_FAM   = 1;
    localparam int BIT_LOCAL_LOOP = 2;
    // reset values
    localparam logic [7:0] RST_FRAMER_MODE_ONE = 8'h00;
    localparam logic [3:0] RST_FREEZE          = 4'h0;
    localparam logic [2:0] RST_LINE_CTRL       = 3'h0;
    // rate index: {family, hi, lo} -> code
    localparam logic [2:0] RATE_2M048  = 3'h0;
    localparam logic [2:0] RATE_1M544  = 3'h4;
    // timing
    localparam int CLK_HZ       = 20000000;
    localparam int SECOND_US    = 1000000;
    localparam int SECOND_CYC   = CLK_HZ / 1000000 * SECOND_US;
    localparam int NUM_CNT      = 4;
endpackage : fmc_pkg

// ---- rtl/fmc_top.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module fmc_top
    import fmc_pkg::*;
#(
    parameter int SECOND_CYCLES = fmc_pkg::SECOND_CYC,
    parameter int CNT_W         = 16
) (
    // clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        NRST_I,
    // register port
    input  wire logic [7:0]  ADDR_I,
    input  wire logic [7:0]  WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [7:0]  RDATA_O,
    // error events, same clock domain, one-cycle pulses
    input  wire logic [3:0]  ERR_EVENT_I,
    // transmit data path
    input  wire logic        TX_HIGHWAY_INPUT_I,
    output logic             LINE_TX_OUT_A_O,
    output logic             LINE_TX_OUT_B_O,
    output logic             LOOP_HIGHWAY_O,
    // mode outputs
    output logic             PCM_LINE_STANDARD_O,
    output logic             CRC6_EN_O,
    output logic             CHANNEL_MAP_SELECT_O,
    output logic             LINK_BIT_REG_INSERT_EN_O,
    output logic      [2:0]  HIGHWAY_RATE_O,
    output logic             SECOND_TICK_O
);
    import fmc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic [1:0]       rst_sync;
    logic             rst_n;
    logic [7:0]       mode_one;
    logic [3:0]       freeze;
    logic [3:0]       freeze_q;
    logic [2:0]       line_ctrl;
    logic [31:0]      sec_cnt;
    logic             tick;
    logic [CNT_W-1:0] live  [NUM_CNT];
    logic [CNT_W-1:0] shown [NUM_CNT];
    logic             err_count_latch_mode;
    logic [7:0]       next_rdata;

    assign rst_n = rst_sync[1];
    assign err_count_latch_mode   = mode_one[BIT_ECM];
    assign tick  = (sec_cnt == 32'(SECOND_CYCLES - 1));

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes, one register per process
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            mode_one <= RST_FRAMER_MODE_ONE;
        end else if (WR_I && ADDR_I == ADDR_FRAMER_MODE_ONE) begin
            mode_one <= WDATA_I;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            freeze <= RST_FREEZE;
        end else if (WR_I && ADDR_I == ADDR_FREEZE) begin
            freeze <= WDATA_I[3:0];
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            line_ctrl <= RST_LINE_CTRL;
        end else if (WR_I && ADDR_I == ADDR_LINE_CTRL) begin
            line_ctrl <= WDATA_I[2:0];
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            freeze_q <= RST_FREEZE;
        end else begin
            freeze_q <= freeze;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one-second timer
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt       <= 32'h0;
            SECOND_TICK_O <= 1'b0;
        end else begin
            sec_cnt       <= tick ? 32'h0 : sec_cnt + 32'h1;
            SECOND_TICK_O <= tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // error counters, one per kind
    for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
        logic freeze_rise;
        logic at_max;

        assign freeze_rise = freeze[g] & ~freeze_q[g];
        assign at_max      = (live[g] == {CNT_W{1'b1}});

        // live count, saturating
        always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
            if (!rst_n) begin
                live[g] <= '0;
            end else if (err_count_latch_mode) begin
                if (tick) begin
                    // restart with this cycle's event so none is lost
                    live[g] <= CNT_W'(ERR_EVENT_I[g]);
                end else if (ERR_EVENT_I[g] && !at_max) begin
                    live[g] <= live[g] + CNT_W'(1);
                end
            end else if (freeze_rise) begin
                live[g] <= '0;
            end else if (ERR_EVENT_I[g] && !at_max) begin
                live[g] <= live[g] + CNT_W'(1);
            end
        end

        // readable copy
        always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
            if (!rst_n) begin
                shown[g] <= '0;
            end else if (err_count_latch_mode) begin
                if (tick) begin
                    shown[g] <= live[g];
                end
            end else if (freeze_rise || !freeze[g]) begin
                shown[g] <= live[g];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux
    always_comb begin
        next_rdata = 8'h00;
        if (ADDR_I == ADDR_FRAMER_MODE_ONE) begin
            next_rdata = mode_one;
        end else if (ADDR_I == ADDR_FREEZE) begin
            next_rdata = {4'h0, freeze};
        end else if (ADDR_I == ADDR_LINE_CTRL) begin
            next_rdata = {5'h00, line_ctrl};
        // halves pair only while shown is held by freeze or latch mode
        end else if (ADDR_I == ADDR_FEC_LO) begin
            next_rdata = shown[0][7:0];
        end else if (ADDR_I == ADDR_FEC_HI) begin
            next_rdata = shown[0][15:8];
        end else if (ADDR_I == ADDR_CEC_LO) begin
            next_rdata = shown[1][7:0];
        end else if (ADDR_I == ADDR_CEC_HI) begin
            next_rdata = shown[1][15:8];
        end else if (ADDR_I == ADDR_CVC_LO) begin
            next_rdata = shown[2][7:0];
        end else if (ADDR_I == ADDR_CVC_HI) begin
            next_rdata = shown[2][15:8];
        end else if (ADDR_I == ADDR_EBC_LO) begin
            next_rdata = shown[3][7:0];
        end else if (ADDR_I == ADDR_EBC_HI) begin
            next_rdata = shown[3][15:8];
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            RDATA_O <= 8'h00;
        end else begin
            RDATA_O <= RD_I ? next_rdata : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit path and mode outputs
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            LINE_TX_OUT_A_O <= 1'b0;
            LINE_TX_OUT_B_O <= 1'b0;
            LOOP_HIGHWAY_O  <= 1'b0;
        end else begin
            if (mode_one[BIT_SEND_AIS]) begin
                LINE_TX_OUT_A_O <= 1'b1;
                LINE_TX_OUT_B_O <= 1'b1;
            end else begin
                LINE_TX_OUT_A_O <= TX_HIGHWAY_INPUT_I;
                LINE_TX_OUT_B_O <= TX_HIGHWAY_INPUT_I;
            end
            LOOP_HIGHWAY_O <= line_ctrl[BIT_LOCAL_LOOP] & TX_HIGHWAY_INPUT_I;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            PCM_LINE_STANDARD_O      <= 1'b0;
            CRC6_EN_O                <= 1'b0;
            CHANNEL_MAP_SELECT_O     <= 1'b0;
            LINK_BIT_REG_INSERT_EN_O <= 1'b0;
            HIGHWAY_RATE_O           <= RATE_2M048;
        end else begin
            PCM_LINE_STANDARD_O      <= mode_one[BIT_PCM_STD];
            CRC6_EN_O                <= mode_one[BIT_CRC6_EN];
            CHANNEL_MAP_SELECT_O     <= mode_one[BIT_CHAN_MAP];
            LINK_BIT_REG_INSERT_EN_O <= mode_one[BIT_LINK_INS];
            HIGHWAY_RATE_O <= {line_ctrl[BIT_RATE_FAM], line_ctrl[BIT_RATE_HI],
                               mode_one[BIT_RATE_LO]};
        end
    end
endmodule : fmc_top

// ---- dv/fmc_top_assertions.sv ----
`timescale 1ns/1ps
module fmc_assertions
    import fmc_pkg::*;
(
    // clock and reset
    input wire logic       CLK_SYS_I,
    input wire logic       NRST_I,
    // register port
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RDATA_O,
    // data path and modes
    input wire logic       TX_HIGHWAY_INPUT_I,
    input wire logic       LINE_TX_OUT_A_O,
    input wire logic       LINE_TX_OUT_B_O,
    input wire logic       LOOP_HIGHWAY_O,
    input wire logic       PCM_LINE_STANDARD_O,
    input wire logic [2:0] HIGHWAY_RATE_O,
    input wire logic       SECOND_TICK_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!NRST_I);
    logic [1:0] rst_age;
    // edges since reset release, saturating
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) rst_age <= 2'h0;
        else if (rst_age != 2'h3) rst_age <= rst_age + 2'h1;
    end
    sequence s_wr_mode; WR_I && ADDR_I == ADDR_FRAMER_MODE_ONE; endsequence
    sequence s_wr_line; WR_I && ADDR_I == ADDR_LINE_CTRL; endsequence
    property p_rd_idle; !RD_I |=> RDATA_O == 8'h00; endproperty
    property p_rate_lo; s_wr_mode |-> ##2 HIGHWAY_RATE_O[0] == $past(WDATA_I[2], 2); endproperty
    property p_rate_fam; s_wr_line |-> ##2 HIGHWAY_RATE_O[2:1] == $past(WDATA_I[1:0], 2); endproperty
    property p_pcm; s_wr_mode |-> ##2 PCM_LINE_STANDARD_O == $past(WDATA_I[5], 2); endproperty
    property p_ais_pair; LINE_TX_OUT_A_O == LINE_TX_OUT_B_O; endproperty
    property p_tx_path; rst_age == 2'h3 && !LINE_TX_OUT_A_O |-> !$past(TX_HIGHWAY_INPUT_I); endproperty
    property p_loop; LOOP_HIGHWAY_O |-> $past(TX_HIGHWAY_INPUT_I); endproperty
    property p_tick; SECOND_TICK_O |=> !SECOND_TICK_O [*8]; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_rate_lo: assert property (p_rate_lo) else $error("rate low bit wrong");
    a_rate_fam: assert property (p_rate_fam) else $error("rate family wrong");
    a_pcm: assert property (p_pcm) else $error("line standard wrong");
    a_ais_pair: assert property (p_ais_pair) else $error("line outputs differ");
    a_tx_path: assert property (p_tx_path) else $error("line data wrong");
    a_loop: assert property (p_loop) else $error("loop data wrong");
    a_tick: assert property (p_tick) else $error("tick too long");
endmodule : fmc_assertions
bind fmc_top fmc_assertions u_chk (.CLK_SYS_I, .NRST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
    .RDATA_O, .TX_HIGHWAY_INPUT_I, .LINE_TX_OUT_A_O, .LINE_TX_OUT_B_O, .LOOP_HIGHWAY_O,
    .PCM_LINE_STANDARD_O, .HIGHWAY_RATE_O, .SECOND_TICK_O);

// ---- dv/fmc_far_model.sv ----
`timescale 1ns/1ps
module fmc_far_model (
    // clock
    input  wire logic       clk_i,
    // event requests
    input  wire logic [3:0] err_req_i,
    // towards the device
    output logic            tx_bit_o = 1'b0,
    output logic      [3:0] err_o    = 4'h0
);
    logic [2:0] pat = 3'h0;
    // highway bits repeat a two-low, two-high pattern
    always_ff @(posedge clk_i) begin
        pat      <= pat + 3'h3;
        tx_bit_o <= pat[1] ^ pat[0];
        err_o    <= err_req_i;
    end
endmodule : fmc_far_model

// ---- dv/fmc_top_bench.sv ----
`timescale 1ns/1ps
module fmc_top_bench;
    import fmc_pkg::*;
    logic       clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, t;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
    logic [3:0] err_req = 4'h0, err_ev;
    logic       tx, la, lb, lp, pcm, crc, chm, lnk, tick;
    logic [2:0] rate;
    int         err_total = 0, cmp_count = 0, k, j;
    fmc_top #(.SECOND_CYCLES(100)) u_dut (.CLK_SYS_I(clk), .NRST_I(nrst), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .ERR_EVENT_I(err_ev),
        .TX_HIGHWAY_INPUT_I(tx), .LINE_TX_OUT_A_O(la), .LINE_TX_OUT_B_O(lb),
        .LOOP_HIGHWAY_O(lp), .PCM_LINE_STANDARD_O(pcm), .CRC6_EN_O(crc),
        .CHANNEL_MAP_SELECT_O(chm), .LINK_BIT_REG_INSERT_EN_O(lnk), .HIGHWAY_RATE_O(rate),
        .SECOND_TICK_O(tick));
    fmc_far_model u_far (.clk_i(clk), .err_req_i(err_req), .tx_bit_o(tx), .err_o(err_ev));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("[ERR] %s exp %h got %h", n, e, g);
            err_total++;
        end
    endtask : chk
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk); wr <= 1'b0;
    endtask : wr8
    task automatic rd8(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk); rd <= 1'b1; addr <= a;
        @(posedge clk); rd <= 1'b0;
        #1 d = rdata;
    endtask : rd8
    // low byte then high byte; halves belong together because shown is held
    task automatic rd16(input logic [7:0] a, input logic [15:0] e, input string n);
        logic [7:0] lo, hi;
        rd8(a, lo);
        rd8(a + 8'h01, hi);
        chk(n, e, {hi, lo});
    endtask : rd16
    task automatic ev(input logic [3:0] m);
        @(posedge clk); err_req <= m;
        @(posedge clk); err_req <= 4'h0;
    endtask : ev
    // wait for the second tick, then stay clear of the update window
    task automatic wtick;
        int n;
        n = 0;
        while (tick !== 1'b1 && n < 150) begin @(posedge clk); #1; n++; end
        chk("tick", 16'h0001, 16'(tick));
        repeat (21) @(posedge clk);
    endtask : wtick
    task give_verdict;
        if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        wr8(ADDR_FRAMER_MODE_ONE, 8'hF0);
        repeat (2) @(posedge clk);
        #1 chk("modes", 16'h000F, 16'({chm, lnk, pcm, crc}));
        rd8(ADDR_FRAMER_MODE_ONE, v); chk("mode_reg", 16'h00F0, 16'(v));
        rd8(8'h00, v); chk("unmapped", 16'h0000, 16'(v));
        for (k = 0; k < 8; k++) begin
            wr8(ADDR_LINE_CTRL, {6'h0, k[2:1]});
            wr8(ADDR_FRAMER_MODE_ONE, {5'h0, k[0], 2'h0});
            repeat (2) @(posedge clk);
            #1 chk("rate", 16'(k[2:0]), 16'(rate));
        end
        chk("modes_off", 16'h0000, 16'({chm, lnk, pcm, crc}));
        wr8(ADDR_LINE_CTRL, 8'h04);
        for (j = 0; j < 2; j++) begin
            wr8(ADDR_FRAMER_MODE_ONE, j ? 8'h00 : 8'h01);
            repeat (2) @(posedge clk);
            for (k = 0; k < 5; k++) begin
                @(posedge clk); t = tx;
                #1 chk("line", 16'({j ? {t, t} : 2'h3, t}), 16'({la, lb, lp}));
            end
        end
        for (k = 0; k < 4; k++) repeat (k + 1) ev(4'h1 << k);
        wr8(ADDR_FREEZE, 8'h0F);
        for (k = 0; k < 4; k++) repeat (2) ev(4'h1 << k);
        for (k = 0; k < 4; k++) rd16(ADDR_FEC_LO + 8'(2 * k), 16'(k + 1), "held");
        wr8(ADDR_FREEZE, 8'h00);
        wr8(ADDR_FREEZE, 8'h0F);
        for (k = 0; k < 4; k++) rd16(ADDR_FEC_LO + 8'(2 * k), 16'h0002, "cleared");
        wr8(ADDR_FREEZE, 8'h00);
        wr8(ADDR_FRAMER_MODE_ONE, 8'h08);
        wtick();
        for (k = 0; k < 4; k++) repeat (k + 1) ev(4'h1 << k);
        wtick();
        for (k = 0; k < 4; k++) rd16(ADDR_FEC_LO + 8'(2 * k), 16'(k + 1), "latched");
        wtick();
        for (k = 0; k < 4; k++) rd16(ADDR_FEC_LO + 8'(2 * k), 16'h0000, "restart");
        give_verdict();
    end
endmodule : fmc_top_bench
